// File: hdl/pcie_aer_serial_regs.sv
// error reporting and serial number configuration registers
module pcie_aer_serial_regs
  import aer_regs_pkg::*;
#(
  parameter int LOG_WIDTH = 128
)(
  // clock and resets
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic                 hot_reset_n,
  // configuration access
  input  wire logic                 cfg_read,
  input  wire logic                 cfg_write,
  input  wire logic [11:0]          cfg_addr,
  input  wire logic [3:0]           cfg_byte_en,
  input  wire logic [31:0]          cfg_wdata,
  output logic      [31:0]          cfg_rdata,
  output logic                      cfg_rdata_valid,
  // error events from the link logic
  input  wire logic [31:0]          uncorr_event,
  input  wire logic [31:0]          corr_event,
  input  wire logic [LOG_WIDTH-1:0] error_header,
  // stored address
  input  wire logic [47:0]          mac_address,
  // error message requests and ecrc controls
  output logic                      report_fatal,
  output logic                      report_nonfatal,
  output logic                      report_correctable,
  output logic                      ecrc_gen_enable,
  output logic                      ecrc_check_enable
);

  if (LOG_WIDTH != 128) begin : g_log_width
    $error("header log must be 128 bits");
  end

  localparam int LOG_WORDS = LOG_WIDTH / 32;

  logic [31:0]          uncorr_status;
  logic [31:0]          uncorr_mask;
  logic [31:0]          uncorr_severity;
  logic [31:0]          corr_status;
  logic [31:0]          corr_mask;
  logic [4:0]           first_error;
  logic [LOG_WIDTH-1:0] header_log;
  logic [63:0]          serial_number;
  logic [31:0]          write_bits;
  logic [31:0]          byte_mask;
  logic [31:0]          uncorr_new;
  logic [31:0]          corr_new;
  logic                 wr_uncorr_status;
  logic                 wr_uncorr_mask;
  logic                 wr_severity;
  logic                 wr_corr_status;
  logic                 wr_corr_mask;
  logic                 wr_control;
  logic [4:0]           next_first_error;
  logic                 log_capture;
  logic [31:0]          read_value;

  serial_number_map serial_map (
    .mac_address   (mac_address),
    .serial_number (serial_number)
  );

  // byte enables widened to a bit mask of written ones
  always_comb begin
    byte_mask  = {{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}},
                  {8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};
    write_bits = byte_mask & cfg_wdata;
  end

  assign wr_uncorr_status = cfg_write && cfg_addr == UNCORR_STATUS_OFFSET;
  assign wr_uncorr_mask   = cfg_write && cfg_addr == UNCORR_MASK_OFFSET;
  assign wr_severity      = cfg_write && cfg_addr == UNCORR_SEVERITY_OFFSET;
  assign wr_corr_status   = cfg_write && cfg_addr == CORR_STATUS_OFFSET;
  assign wr_corr_mask     = cfg_write && cfg_addr == CORR_MASK_OFFSET;
  assign wr_control       = cfg_write && cfg_addr == CAP_CONTROL_OFFSET;

  // only implemented sources reach the status bits
  assign uncorr_new = uncorr_event & UNCORR_IMPL_BITS;
  assign corr_new   = corr_event & CORR_IMPL_BITS;

  // uncorrectable status: sticky, set wins over write-one clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      uncorr_status <= 32'h0000_0000;
    end else begin
      uncorr_status <= (uncorr_status
                       & ~(wr_uncorr_status ? write_bits : 32'h0000_0000))
                       | uncorr_new;
    end
  end

  // uncorrectable mask, writable implemented bits only
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      uncorr_mask <= UNCORR_MASK_RESET;
    end else if (wr_uncorr_mask) begin
      uncorr_mask <= (uncorr_mask & ~(UNCORR_IMPL_BITS & byte_mask))
                     | (write_bits & UNCORR_IMPL_BITS);
    end
  end

  // severity, writable implemented bits only
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      uncorr_severity <= SEVERITY_RESET;
    end else if (wr_severity) begin
      uncorr_severity <= (uncorr_severity
                         & ~(UNCORR_IMPL_BITS & byte_mask))
                         | (write_bits & UNCORR_IMPL_BITS);
    end
  end

  // correctable status: sticky, set wins over write-one clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      corr_status <= 32'h0000_0000;
    end else begin
      corr_status <= (corr_status
                     & ~(wr_corr_status ? write_bits : 32'h0000_0000))
                     | corr_new;
    end
  end

  // correctable mask
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      corr_mask <= CORR_MASK_RESET;
    end else if (wr_corr_mask) begin
      corr_mask <= (corr_mask & ~(CORR_IMPL_BITS & byte_mask))
                   | (write_bits & CORR_IMPL_BITS);
    end
  end

  // ecrc enables, sticky
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ecrc_gen_enable   <= 1'b0;
      ecrc_check_enable <= 1'b0;
    end else if (wr_control && cfg_byte_en[0]) begin
      ecrc_gen_enable <= cfg_wdata[ECRC_GEN_EN];
    end
    if (reset_n && wr_control && cfg_byte_en[1]) begin
      ecrc_check_enable <= cfg_wdata[ECRC_CHK_EN];
    end
  end

  // lowest newly set source becomes the first error
  always_comb begin
    next_first_error = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (uncorr_new[i]) begin
        next_first_error = 5'(i);
      end
    end
  end

  // capture only when no uncorrectable error is pending
  assign log_capture = (|uncorr_new) && !(|uncorr_status);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      first_error <= 5'h00;
    end else if (log_capture) begin
      first_error <= next_first_error;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      header_log <= '0;
    end else if (log_capture) begin
      header_log <= error_header;
    end
  end

  // message requests, gated by mask; status is not
  always_ff @(posedge clock) begin
    if (!reset_n || !hot_reset_n) begin
      report_fatal       <= 1'b0;
      report_nonfatal    <= 1'b0;
      report_correctable <= 1'b0;
    end else begin
      report_fatal       <= |(uncorr_new & ~uncorr_mask
                              & uncorr_severity);
      report_nonfatal    <= |(uncorr_new & ~uncorr_mask
                              & ~uncorr_severity);
      report_correctable <= |(corr_new & ~corr_mask);
    end
  end

  // read multiplexer
  always_comb begin
    read_value = 32'h0000_0000;
    unique case (cfg_addr)
      AER_HEADER_OFFSET:      read_value = AER_HEADER_VALUE;
      UNCORR_STATUS_OFFSET:   read_value = uncorr_status;
      UNCORR_MASK_OFFSET:     read_value = uncorr_mask;
      UNCORR_SEVERITY_OFFSET: read_value = uncorr_severity
                                           | SEVERITY_FIXED_ONES;
      CORR_STATUS_OFFSET:     read_value = corr_status;
      CORR_MASK_OFFSET:       read_value = corr_mask;
      CAP_CONTROL_OFFSET: begin
        read_value[FIRST_ERROR_MSB:0] = first_error;
        read_value[ECRC_GEN_CAP]      = 1'b1;
        read_value[ECRC_GEN_EN]       = ecrc_gen_enable;
        read_value[ECRC_CHK_CAP]      = 1'b1;
        read_value[ECRC_CHK_EN]       = ecrc_check_enable;
        // bits 9..11 stay zero
      end
      SERIAL_HEADER_OFFSET:   read_value = SERIAL_HEADER_VALUE;
      SERIAL_LOW_OFFSET:      read_value = serial_number[31:0];
      SERIAL_HIGH_OFFSET:     read_value = serial_number[63:32];
      HINT_HEADER_OFFSET:     read_value = HINT_HEADER_VALUE;
      default: begin
        for (int w = 0; w < LOG_WORDS; w++) begin
          if (cfg_addr == HEADER_LOG_OFFSET + 12'(4 * w)) begin
            read_value = header_log[32*w +: 32];
          end
        end
      end
    endcase
  end

  // read data one cycle after the request
  always_ff @(posedge clock) begin
    if (!reset_n || !hot_reset_n) begin
      cfg_rdata       <= 32'h0000_0000;
      cfg_rdata_valid <= 1'b0;
    end else begin
      cfg_rdata_valid <= cfg_read;
      if (cfg_read) begin
        cfg_rdata <= read_value;
      end
    end
  end

  // checks
  chk_uncorr_set: assert property (
    @(posedge clock) disable iff (!reset_n)
    uncorr_event[12] |=> uncorr_status[12])
    else $error("uncorrectable status bit not set by its event");

  chk_unimpl_zero: assert property (
    @(posedge clock) disable iff (!reset_n)
    (uncorr_status & ~UNCORR_IMPL_BITS) == 32'h0000_0000
    && (uncorr_mask & ~UNCORR_IMPL_BITS) == 32'h0000_0000
    && (uncorr_severity & ~UNCORR_IMPL_BITS) == 32'h0000_0000)
    else $error("unsupported uncorrectable bit became set");

  chk_mask_blocks: assert property (
    @(posedge clock) disable iff (!reset_n)
    ((uncorr_new & ~uncorr_mask) == 32'h0000_0000 && hot_reset_n)
    |=> !report_fatal && !report_nonfatal)
    else $error("masked uncorrectable error was reported");

  chk_fatal_route: assert property (
    @(posedge clock) disable iff (!reset_n)
    (hot_reset_n && uncorr_new[18] && !uncorr_mask[18]
     && uncorr_severity[18]) |=> report_fatal)
    else $error("fatal error not reported as fatal");

  chk_nonfatal_route: assert property (
    @(posedge clock) disable iff (!reset_n)
    (hot_reset_n && uncorr_new[14] && !uncorr_mask[14]
     && !uncorr_severity[14]) |=> report_nonfatal)
    else $error("non-fatal error not reported as non-fatal");

  chk_severity_read: assert property (
    @(posedge clock) disable iff (!reset_n || !hot_reset_n)
    (cfg_read && cfg_addr == UNCORR_SEVERITY_OFFSET)
    |=> cfg_rdata[3:0] == 4'h1 && !cfg_rdata[5]
        && cfg_rdata[25:21] == 5'h00)
    else $error("severity read showed a fixed bit wrong");

  chk_w1c_clear: assert property (
    @(posedge clock) disable iff (!reset_n)
    (wr_corr_status && write_bits[0] && !corr_event[0])
    |=> !corr_status[0])
    else $error("write one did not clear correctable status");

  chk_zero_keeps: assert property (
    @(posedge clock) disable iff (!reset_n)
    (wr_corr_status && !write_bits[6] && corr_status[6])
    |=> corr_status[6])
    else $error("write zero changed correctable status");

  chk_corr_mask: assert property (
    @(posedge clock) disable iff (!reset_n)
    (hot_reset_n && (corr_new & ~corr_mask) == 32'h0000_0000)
    |=> !report_correctable)
    else $error("masked correctable error was reported");

  chk_corr_report: assert property (
    @(posedge clock) disable iff (!reset_n)
    (hot_reset_n && corr_new[0] && !corr_mask[0])
    |=> report_correctable)
    else $error("unmasked correctable error was not reported");

  chk_ecrc_hold: assert property (
    @(posedge clock) disable iff (!reset_n)
    !wr_control |=> $stable(ecrc_gen_enable) && $stable(ecrc_check_enable))
    else $error("ecrc enable changed without a control write");

  chk_first_held: assert property (
    @(posedge clock) disable iff (!reset_n)
    (|uncorr_status) |=> $stable(first_error) && $stable(header_log))
    else $error("first error pointer moved while errors pending");

  chk_sticky_hot: assert property (
    @(posedge clock) disable iff (!reset_n)
    (!hot_reset_n && !cfg_write && uncorr_new == 32'h0000_0000
     && corr_new == 32'h0000_0000)
    |=> $stable(uncorr_status) && $stable(corr_status)
        && $stable(uncorr_mask) && $stable(first_error))
    else $error("sticky field changed under hot reset");

  chk_read_lat: assert property (@(posedge clock)
    disable iff (!reset_n || !hot_reset_n)
    cfg_read |=> cfg_rdata_valid ##1 !cfg_rdata_valid || $past(cfg_read))
    else $error("read data valid not one cycle after request");

endmodule // pcie_aer_serial_regs

// File: hdl/aer_regs_pkg.sv
// constants for the error reporting and serial number register block
package aer_regs_pkg;

  // configuration byte offsets
  localparam logic [11:0] AER_HEADER_OFFSET      = 12'h100;
  localparam logic [11:0] UNCORR_STATUS_OFFSET   = 12'h104;
  localparam logic [11:0] UNCORR_MASK_OFFSET     = 12'h108;
  localparam logic [11:0] UNCORR_SEVERITY_OFFSET = 12'h10C;
  localparam logic [11:0] CORR_STATUS_OFFSET     = 12'h110;
  localparam logic [11:0] CORR_MASK_OFFSET       = 12'h114;
  localparam logic [11:0] CAP_CONTROL_OFFSET     = 12'h118;
  localparam logic [11:0] HEADER_LOG_OFFSET      = 12'h11C;
  localparam logic [11:0] SERIAL_HEADER_OFFSET   = 12'h140;
  localparam logic [11:0] SERIAL_LOW_OFFSET      = 12'h144;
  localparam logic [11:0] SERIAL_HIGH_OFFSET     = 12'h148;
  localparam logic [11:0] HINT_HEADER_OFFSET     = 12'h1A0;

  // capability headers: id, version, next pointer
  localparam logic [31:0] AER_HEADER_VALUE    = 32'h1402_0001;
  localparam logic [31:0] SERIAL_HEADER_VALUE = 32'h1A01_0003;
  localparam logic [31:0] HINT_HEADER_VALUE   = 32'h1C01_0017;

  // implemented uncorrectable bits 4 and 12..20
  localparam logic [31:0] UNCORR_IMPL_BITS    = 32'h001F_F010;
  localparam logic [31:0] UNCORR_MASK_RESET   = 32'h0000_0000;
  localparam logic [31:0] SEVERITY_RESET      = 32'h0006_2010;
  localparam logic [31:0] SEVERITY_FIXED_ONES = 32'h0000_0001;

  // implemented correctable bits 0, 6..8, 12, 13
  localparam logic [31:0] CORR_IMPL_BITS  = 32'h0000_31C1;
  localparam logic [31:0] CORR_MASK_RESET = 32'h0000_2000;

  // capability and control field positions
  localparam int FIRST_ERROR_MSB = 4;
  localparam int ECRC_GEN_CAP    = 5;
  localparam int ECRC_GEN_EN     = 6;
  localparam int ECRC_CHK_CAP    = 7;
  localparam int ECRC_CHK_EN     = 8;

  // serial number layout
  localparam logic [15:0] SERIAL_LABEL = 16'hFFFF;

endpackage : aer_regs_pkg

// File: hdl/serial_number_map.sv
// forms the 64-bit serial number from the stored 48-bit address
module serial_number_map
  import aer_regs_pkg::*;
(
  // stored address, byte 0 in bits 7:0
  input  wire logic [47:0] mac_address,
  // serial number, byte 0 in bits 7:0
  output logic      [63:0] serial_number
);

  // address bytes 5..3 first, then the label, then bytes 2..0
  assign serial_number = {mac_address[7:0],
                          mac_address[15:8],
                          mac_address[23:16],
                          SERIAL_LABEL,
                          mac_address[31:24],
                          mac_address[39:32],
                          mac_address[47:40]};

endmodule // serial_number_map

// File: verification/cfg_host_model.sv
// configuration host model issuing config reads and writes
module cfg_host_model (
  // clock
  input  wire logic        clock,
  // configuration access
  output logic             cfg_read,
  output logic             cfg_write,
  output logic      [11:0] cfg_addr,
  output logic      [3:0]  cfg_byte_en,
  output logic      [31:0] cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rdata_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cfg_read    = 1'b0;
    cfg_write   = 1'b0;
    cfg_addr    = 12'h000;
    cfg_byte_en = 4'h0;
    cfg_wdata   = 32'h0000_0000;
  end

  // one-cycle write; released data is inverted so it is never reused
  task automatic write_cfg(input logic [11:0] addr, input logic [31:0] data,
                           input logic [3:0] be);
    @(negedge clock);
    cfg_write   = 1'b1;
    cfg_addr    = addr;
    cfg_byte_en = be;
    cfg_wdata   = data;
    @(negedge clock);
    cfg_write   = 1'b0;
    cfg_wdata   = ~data;
  endtask

  // one-cycle read, data taken while valid stands
  task automatic read_cfg(input logic [11:0] addr, output logic [31:0] data);
    int n;
    @(negedge clock);
    cfg_read = 1'b1;
    cfg_addr = addr;
    @(negedge clock);
    cfg_read = 1'b0;
    n = 0;
    while (cfg_rdata_valid !== 1'b1 && n < 3) begin
      @(negedge clock);
      n++;
    end
    data = (cfg_rdata_valid === 1'b1) ? cfg_rdata : 32'hXXXX_XXXX;
  endtask
endmodule // cfg_host_model

// File: verification/tb.sv
// testbench for the error reporting and serial number registers
module tb;
  import aer_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic          clock;
  logic          reset_n;
  logic          hot_reset_n;
  logic          cfg_read;
  logic          cfg_write;
  logic [11:0]   cfg_addr;
  logic [3:0]    cfg_byte_en;
  logic [31:0]   cfg_wdata;
  logic [31:0]   cfg_rdata;
  logic          cfg_rdata_valid;
  logic [31:0]   uncorr_event;
  logic [31:0]   corr_event;
  logic [127:0]  error_header;
  logic [47:0]   mac_address;
  logic          report_fatal;
  logic          report_nonfatal;
  logic          report_correctable;
  logic          ecrc_gen_enable;
  logic          ecrc_check_enable;
  int            failures;
  int            n_compared;
  int            cycles;
  logic [127:0]  hdr;

  pcie_aer_serial_regs #(.LOG_WIDTH(128)) pcie_aer_serial_regs_i (
    .clock(clock), .reset_n(reset_n), .hot_reset_n(hot_reset_n),
    .cfg_read(cfg_read), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
    .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rdata_valid(cfg_rdata_valid),
    .uncorr_event(uncorr_event), .corr_event(corr_event),
    .error_header(error_header), .mac_address(mac_address),
    .report_fatal(report_fatal), .report_nonfatal(report_nonfatal),
    .report_correctable(report_correctable),
    .ecrc_gen_enable(ecrc_gen_enable),
    .ecrc_check_enable(ecrc_check_enable));

  cfg_host_model cfg_host_model_i (
    .clock(clock), .cfg_read(cfg_read), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rdata_valid(cfg_rdata_valid));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] v;
    cfg_host_model_i.read_cfg(addr, v);
    check(v, exp, "read");
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    cfg_host_model_i.write_cfg(addr, data, 4'hF);
  endtask

  // exp is {fatal, nonfatal, correctable}; pulses must last one cycle
  task automatic pulse(input logic [31:0] u, input logic [31:0] c,
                       input logic [2:0] exp);
    @(negedge clock);
    uncorr_event = u;
    corr_event   = c;
    @(negedge clock);
    uncorr_event = 32'h0000_0000;
    corr_event   = 32'h0000_0000;
    check({29'h0, report_fatal, report_nonfatal, report_correctable},
          {29'h0, exp}, "report");
    @(negedge clock);
    check({29'h0, report_fatal, report_nonfatal, report_correctable},
          32'h0000_0000, "report end");
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("[FAIL] %0t run too long", $time);
      close_out();
    end
  end

  initial begin
    hot_reset_n  = 1'b1;
    failures     = 0;
    n_compared   = 0;
    cycles       = 0;
    uncorr_event = 32'h0000_0000;
    corr_event   = 32'h0000_0000;
    hdr          = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    error_header = 128'h0;
    mac_address  = 48'h0A0B_0C0D_0E0F;
    do_reset();
    rd(UNCORR_STATUS_OFFSET, 32'h0000_0000);
    rd(UNCORR_MASK_OFFSET, 32'h0000_0000);
    rd(UNCORR_SEVERITY_OFFSET, 32'h0006_2011);
    rd(CORR_STATUS_OFFSET, 32'h0000_0000);
    rd(CORR_MASK_OFFSET, 32'h0000_2000);
    rd(CAP_CONTROL_OFFSET, 32'h0000_00A0);
    for (int i = 0; i < 4; i++) begin
      rd(HEADER_LOG_OFFSET + 12'(4 * i), 32'h0000_0000);
    end
    rd(SERIAL_HEADER_OFFSET, 32'h1A01_0003);
    rd(SERIAL_LOW_OFFSET, {8'hFF, mac_address[31:24],
       mac_address[39:32], mac_address[47:40]});
    rd(SERIAL_HIGH_OFFSET, {mac_address[7:0], mac_address[15:8],
       mac_address[23:16], 8'hFF});
    rd(HINT_HEADER_OFFSET, 32'h1C01_0017);
    rd(12'h200, 32'h0000_0000);
    cfg_host_model_i.write_cfg(UNCORR_MASK_OFFSET, 32'hFFFF_FFFF, 4'h1);
    rd(UNCORR_MASK_OFFSET, 32'h0000_0010);
    wr(UNCORR_MASK_OFFSET, 32'hFFFF_FFFF);
    wr(UNCORR_SEVERITY_OFFSET, 32'hFFFF_FFFF);
    wr(CORR_MASK_OFFSET, 32'hFFFF_FFFF);
    wr(CAP_CONTROL_OFFSET, 32'hFFFF_FFFF);
    rd(UNCORR_MASK_OFFSET, 32'h001F_F010);
    rd(UNCORR_SEVERITY_OFFSET, 32'h001F_F011);
    rd(CORR_MASK_OFFSET, 32'h0000_31C1);
    rd(CAP_CONTROL_OFFSET, 32'h0000_01E0);
    check({31'h0, ecrc_gen_enable}, 32'h1, "gen on");
    check({31'h0, ecrc_check_enable}, 32'h1, "check on");
    wr(UNCORR_MASK_OFFSET, 32'h0000_0000);
    wr(UNCORR_SEVERITY_OFFSET, 32'h0006_2010);
    wr(CORR_MASK_OFFSET, 32'h0000_2000);
    wr(CAP_CONTROL_OFFSET, 32'h0000_0000);
    check({31'h0, ecrc_gen_enable}, 32'h0, "gen off");
    check({31'h0, ecrc_check_enable}, 32'h0, "check off");
    error_header = hdr;
    pulse(32'h0004_0000, 32'h0, 3'b100);
    error_header = ~hdr;
    pulse(32'h0000_4000, 32'h0, 3'b010);
    rd(CAP_CONTROL_OFFSET, 32'h0000_00B2);
    rd(HEADER_LOG_OFFSET, hdr[31:0]);
    rd(HEADER_LOG_OFFSET + 12'hC, hdr[127:96]);
    wr(UNCORR_MASK_OFFSET, 32'h0000_1000);
    pulse(32'h0000_1000, 32'h0, 3'b000);
    pulse(32'h03E0_0020, 32'h0, 3'b000);
    rd(UNCORR_STATUS_OFFSET, 32'h0004_5000);
    wr(UNCORR_STATUS_OFFSET, 32'h0000_4000);
    rd(UNCORR_STATUS_OFFSET, 32'h0004_1000);
    pulse(32'h0, 32'h0000_0041, 3'b001);
    pulse(32'h0, 32'h0000_2000, 3'b000);
    rd(CORR_STATUS_OFFSET, 32'h0000_2041);
    wr(CORR_STATUS_OFFSET, 32'h0000_0000);
    rd(CORR_STATUS_OFFSET, 32'h0000_2041);
    wr(CORR_STATUS_OFFSET, 32'h0000_0001);
    rd(CORR_STATUS_OFFSET, 32'h0000_2040);
    wr(UNCORR_MASK_OFFSET, 32'hFFFF_FFFF);
    pulse(32'hFFFF_FFFF, 32'h0, 3'b000);
    rd(UNCORR_STATUS_OFFSET, 32'h001F_F010);
    wr(CAP_CONTROL_OFFSET, 32'h0000_0040);
    @(negedge clock);
    hot_reset_n = 1'b0;
    @(negedge clock);
    hot_reset_n = 1'b1;
    check(cfg_rdata, 32'h0000_0000, "rdata cleared");
    rd(UNCORR_STATUS_OFFSET, 32'h001F_F010);
    rd(UNCORR_MASK_OFFSET, 32'h001F_F010);
    rd(CAP_CONTROL_OFFSET, 32'h0000_00F2);
    rd(HEADER_LOG_OFFSET, hdr[31:0]);
    check({31'h0, ecrc_gen_enable}, 32'h1, "ecrc kept");
    wr(UNCORR_SEVERITY_OFFSET, 32'h0000_0000);
    wr(CORR_MASK_OFFSET, 32'h0000_0000);
    do_reset();
    rd(UNCORR_STATUS_OFFSET, 32'h0000_0000);
    rd(UNCORR_MASK_OFFSET, 32'h0000_0000);
    rd(CORR_STATUS_OFFSET, 32'h0000_0000);
    rd(CAP_CONTROL_OFFSET, 32'h0000_00A0);
    rd(HEADER_LOG_OFFSET, 32'h0000_0000);
    check({31'h0, ecrc_gen_enable}, 32'h0, "gen reset");
    rd(UNCORR_SEVERITY_OFFSET, 32'h0006_2011);
    rd(CORR_MASK_OFFSET, 32'h0000_2000);
    close_out();
  end
endmodule // tb
